/* thermal_sensor_params.svh */
`ifndef THERMAL_SENSOR_PARAMS_SVH
`define THERMAL_SENSOR_PARAMS_SVH
`define CMD_RESET 8'h00
`define CMD_RD_CONFIG 8'h03
`define CMD_RD_RATE 8'h04
`define CMD_WR_CONFIG 8'h09
`define CMD_WR_RATE 8'h0A
`define CMD_ONE_SHOT 8'h0F
`define CFG_MASK_BIT 7
`define CFG_STBY_BIT 6
`define CFG_RESET 8'h00
`define RATE_RESET 8'h02
`define RATE_MAX 8'h07
`define PERIOD_AT_RESET 8'h20
`define ARA_ADDR 7'h0C
`define ADDR_RESET 7'h18
`define NIB_GRP_LO 4'h3
`define NIB_GRP_FL 4'h5
`define NIB_GRP_HI 4'h9
`define SUB_GRP_LO 3'h0
`define SUB_GRP_FL 3'h1
`define SUB_GRP_HI 3'h4
`define MCLK_PERIOD_NS 10
`define TICK_PERIOD_NS 125000000
`define BOOT_LATCH 2'h2
`define BOOT_LAST 2'h3
`define BYTE_LAST_BIT 4'h7
`define ACK_SLOT 4'h8
`endif

/* thermal_sensor_pkg.sv */
package thermal_sensor_pkg;
  typedef enum logic [1:0] {LVL_LOW, LVL_FLOAT, LVL_HIGH} pin_lvl_e;
  // each select pin read once with weak pull-up and once with pull-down
  typedef struct packed {
    logic pu_lvl;
    logic pd_lvl;
  } sel_pin_s;
  typedef struct packed {
    logic start;
    logic stop;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic tx_done;
  } smb_ev_s;
  typedef enum {X_ADDR, X_CMD, X_DATA, X_DONE} xfer_state_e;
endpackage

/* smb_byte_link.sv */
`timescale 1ns/100ps
`include "thermal_sensor_params.svh"
module smb_byte_link
  import thermal_sensor_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ack_en,
  input wire logic [7:0] tx_byte,
  output smb_ev_s ev,
  output logic sda_oe
);
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic active_r, first_r, tx_r, drop_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, txsh_r;
  logic scl_rise, scl_fall, start_det, stop_det, live;

  // two flops per line, a third stage only for edge finding
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign live = active_r & ~drop_r;

  // bit counting and frame tracking; a nacked address drops the frame
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= 1'b0;
      first_r <= 1'b0;
      tx_r <= 1'b0;
      drop_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end else if (start_det) begin
      active_r <= 1'b1;
      first_r <= 1'b1;
      tx_r <= 1'b0;
      drop_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (stop_det) begin
      active_r <= 1'b0;
    end else if (scl_rise && live) begin
      if (cnt_r == `ACK_SLOT) begin
        cnt_r <= 4'h0;
        first_r <= 1'b0;
        if (first_r) begin
          tx_r <= sh_r[0] & ack_en;
          drop_r <= ~ack_en;
        end else if (tx_r) begin
          drop_r <= sda_s_r; // master nack ends the read
        end
      end else begin
        cnt_r <= cnt_r + 4'h1;
        sh_r <= {sh_r[6:0], sda_s_r};
      end
    end
  end

  // one-cycle event pulses towards the command logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ev <= '0;
    end else begin
      ev.start <= start_det;
      ev.stop <= stop_det;
      ev.rx_valid <= scl_rise & live & ~tx_r & (cnt_r == `BYTE_LAST_BIT);
      ev.tx_done <= scl_rise & live & tx_r & (cnt_r == `ACK_SLOT);
      if (scl_rise && live && cnt_r == `BYTE_LAST_BIT) begin
        ev.rx_byte <= {sh_r[6:0], sda_s_r};
      end
    end
  end

  // data line changes only while the clock is low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe <= 1'b0;
      txsh_r <= 8'h00;
    end else if (start_det || stop_det || drop_r) begin
      sda_oe <= 1'b0;
    end else if (scl_fall && active_r) begin
      if (cnt_r == `ACK_SLOT) begin
        sda_oe <= ~tx_r & ack_en;
      end else if (tx_r && cnt_r == 4'h0) begin
        txsh_r <= tx_byte;
        sda_oe <= ~tx_byte[7];
      end else if (tx_r) begin
        sda_oe <= ~txsh_r[3'(`BYTE_LAST_BIT - cnt_r)];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end
endmodule

/* thermal_sensor_ctrl.sv */
`timescale 1ns/100ps
`include "thermal_sensor_params.svh"
// How it works
// R1: writing standby bit 6 high aborts any conversion and enters standby.
// R2: in standby a one-shot command still runs one conversion.
// R3: standby bit clear means automatic, timed conversions.
// R4: standby bit resets to 0, so auto mode follows reset.
// R5: config byte read and written only by its own commands.
// R6: mask bit 7, reset 0, gates alert output and alert-address answers.
// R7: with mask set the alert response read is not acknowledged.
// R8: config bits 5 to 0 are reserved, stored without function.
// R9: rate byte 00h..07h gives 0.0625 to 8 Hz; higher values reserved.
// R10: rate byte governs timing only in automatic mode.
// R11: rate byte resets to 02h, 0.25 conversions per second.
// R12: true rate may deviate thirty percent from nominal.
// R13: limit crossing or open diode raises an alert.
// R14: a latched alert pulls the open-drain alert low when unmasked.
// R15: alert response read releases alert unless the fault persists.
// R16: status read or mask set never release a latched alert.
// R17: three upper nibbles with select pins give nine slave addresses.
// R18: pin 0 picks nibble and base, pin 1 adds 0, 1 or 2.
// R19: each select pin decodes low, high or floating.
// R20: select pins latched at power-up and at each conversion start.
// R21: master never issues addresses with upper nibble zero.
// R22: alert response returns own 7-bit address in the upper bits.
// R23: config read 03h, write 09h; rate read 04h, write 0Ah.
module thermal_sensor_ctrl
  import thermal_sensor_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `MCLK_PERIOD_NS
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic smb_clk,
  input wire logic smb_dat_in,
  output logic smb_dat_out,
  output logic smb_dat_oe,
  output logic alert_out_n_out,
  output logic alert_out_n_oe,
  input sel_pin_s [1:0] sensor_addr_select,
  output logic conv_start,
  output logic conv_abort,
  output logic conv_busy,
  input wire logic conv_done,
  input wire logic limit_fault,
  input wire logic diode_open,
  output logic [7:0] cmd_ptr,
  input wire logic [7:0] ext_rd_byte,
  output logic ext_wr_stb,
  output logic [7:0] ext_wr_data
);
  sel_pin_s [1:0] sel_m_r, sel_s_r;
  logic [1:0] boot_cnt_r;
  logic [6:0] own_addr_r;
  smb_ev_s ev;
  xfer_state_e st_r;
  logic ack_r, ara_sel_r, hit_own, hit_ara;
  logic [7:0] cmd_r, config_r, rate_r, tx_byte;
  logic cmd_wr, data_wr, cfg_wr, stby_wr, one_shot_req;
  logic [23:0] tick_cnt_r;
  logic tick, auto_due, start_now, standby, mask;
  logic [7:0] rate_eff, period_ticks, conv_tmr_r;
  logic alert_r, fault, ara_clr;

  function automatic pin_lvl_e lvl_of(sel_pin_s p);
    if (p.pu_lvl && p.pd_lvl) return LVL_HIGH;
    else if (p.pu_lvl) return LVL_FLOAT;
    else return LVL_LOW;
  endfunction

  // pin 0 picks the nibble and base, pin 1 steps within the group
  function automatic logic [6:0] addr_of(sel_pin_s [1:0] p);
    logic [3:0] nib;
    logic [2:0] base;
    nib = `NIB_GRP_LO; // R18
    base = `SUB_GRP_LO;
    if (lvl_of(p[0]) == LVL_FLOAT) begin
      nib = `NIB_GRP_FL;
      base = `SUB_GRP_FL;
    end else if (lvl_of(p[0]) == LVL_HIGH) begin
      nib = `NIB_GRP_HI;
      base = `SUB_GRP_HI;
    end
    return {nib, base + 3'(lvl_of(p[1]))}; // R17 R19
  endfunction

  // select pins come from outside: two flops before any decode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sel_m_r <= '0;
      sel_s_r <= '0;
    end else begin
      sel_m_r <= sensor_addr_select;
      sel_s_r <= sel_m_r;
    end
  end

  // latch once the synchroniser has settled, then at each conversion
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_cnt_r <= 2'h0;
      own_addr_r <= `ADDR_RESET;
    end else begin
      if (boot_cnt_r != `BOOT_LAST) boot_cnt_r <= boot_cnt_r + 2'h1;
      if (boot_cnt_r == `BOOT_LATCH || start_now) begin
        own_addr_r <= addr_of(sel_s_r); // R20
      end
    end
  end

  smb_byte_link u_link (
    .mclk(mclk),
    .rst_b(rst_b),
    .scl_in(smb_clk),
    .sda_in(smb_dat_in),
    .ack_en(ack_r),
    .tx_byte(tx_byte),
    .ev(ev),
    .sda_oe(smb_dat_oe)
  );
  assign smb_dat_out = 1'b0;

  assign standby = config_r[`CFG_STBY_BIT];
  assign mask = config_r[`CFG_MASK_BIT];
  assign hit_own = ev.rx_byte[7:1] == own_addr_r;
  // masked alert: the response address read goes unanswered
  assign hit_ara = ev.rx_byte[7:1] == `ARA_ADDR && ev.rx_byte[0] &&
                   alert_r && !mask; // R6 R7

  // frame sequence: address, command, data; reads use the pointer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= X_ADDR;
      ack_r <= 1'b0;
      ara_sel_r <= 1'b0;
    end else if (ev.start) begin
      st_r <= X_ADDR;
      ara_sel_r <= 1'b0;
    end else if (ev.rx_valid) begin
      unique case (st_r)
        X_ADDR: begin
          ack_r <= hit_own | hit_ara;
          ara_sel_r <= hit_ara;
          st_r <= (hit_own && !ev.rx_byte[0]) ? X_CMD : X_DONE;
        end
        X_CMD: begin
          ack_r <= 1'b1;
          st_r <= X_DATA;
        end
        X_DATA: begin
          ack_r <= 1'b1;
          st_r <= X_DONE;
        end
        X_DONE: ack_r <= 1'b0;
      endcase
    end
  end

  assign cmd_wr = ev.rx_valid && st_r == X_CMD;
  assign data_wr = ev.rx_valid && st_r == X_DATA;
  assign cfg_wr = data_wr && cmd_r == `CMD_WR_CONFIG; // R5 R23
  assign stby_wr = cfg_wr && ev.rx_byte[`CFG_STBY_BIT];
  assign one_shot_req = cmd_wr && ev.rx_byte == `CMD_ONE_SHOT;

  // read data: alert response, own registers, else the outside bank
  always_comb begin
    if (ara_sel_r) tx_byte = {own_addr_r, 1'b1}; // R22
    else if (cmd_r == `CMD_RD_CONFIG) tx_byte = config_r; // R5 R23
    else if (cmd_r == `CMD_RD_RATE) tx_byte = rate_r; // R23
    else tx_byte = ext_rd_byte;
  end

  // register writes; a write through a read code goes to the outside bank
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r <= `CMD_RESET;
      config_r <= `CFG_RESET; // R4 R6 R8
      rate_r <= `RATE_RESET; // R11
      ext_wr_stb <= 1'b0;
      ext_wr_data <= 8'h00;
    end else begin
      ext_wr_stb <= 1'b0;
      if (cmd_wr) cmd_r <= ev.rx_byte;
      if (cfg_wr) config_r <= ev.rx_byte; // R1 R3 R6 R8
      if (data_wr && cmd_r == `CMD_WR_RATE) rate_r <= ev.rx_byte; // R9
      if (data_wr && cmd_r != `CMD_WR_CONFIG &&
          cmd_r != `CMD_WR_RATE) begin
        ext_wr_stb <= 1'b1;
        ext_wr_data <= ev.rx_byte;
      end
    end
  end
  assign cmd_ptr = cmd_r;

  // 8 Hz timebase; reserved rate codes run at the fastest rate
  assign tick = tick_cnt_r == 24'(TICK_CYCLES - 1); // R12
  assign rate_eff = (rate_r > `RATE_MAX) ? `RATE_MAX : rate_r;
  assign period_ticks = 8'h01 << 3'(`RATE_MAX - rate_eff); // R9
  assign auto_due = !standby && tick &&
                    conv_tmr_r + 8'h01 >= period_ticks; // R3 R10

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= 24'h000000;
      conv_tmr_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick ? 24'h000000 : tick_cnt_r + 24'h000001;
      if (standby || auto_due) conv_tmr_r <= 8'h00; // R10
      else if (tick) conv_tmr_r <= conv_tmr_r + 8'h01;
    end
  end

  // one-shot only counts in standby and while idle
  assign start_now = !conv_busy && !stby_wr &&
                     (auto_due || (one_shot_req && standby)); // R2 R3

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      conv_start <= start_now;
      conv_abort <= stby_wr & conv_busy; // R1
      if (start_now) conv_busy <= 1'b1;
      else if (conv_done || stby_wr) conv_busy <= 1'b0; // R1
    end
  end

  // alert latch: a fault present in the clearing cycle wins
  assign fault = limit_fault | diode_open; // R13
  assign ara_clr = ev.tx_done & ara_sel_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alert_r <= 1'b0;
      alert_out_n_oe <= 1'b0;
    end else begin
      alert_r <= fault | (alert_r & ~ara_clr); // R13 R15 R16
      alert_out_n_oe <= alert_r & ~mask; // R14
    end
  end
  assign alert_out_n_out = 1'b0;

  property p_fault_latch;
    @(posedge mclk) disable iff (!rst_b) fault |=> alert_r;
  endproperty
  a_fault_latch: assert property (p_fault_latch) // R13
    else $error("fault did not latch the alert");

  property p_alert_drive;
    @(posedge mclk) disable iff (!rst_b)
      alert_r && !mask |=> alert_out_n_oe;
  endproperty
  a_alert_drive: assert property (p_alert_drive) // R14
    else $error("unmasked alert not driven");

  property p_ara_release;
    @(posedge mclk) disable iff (!rst_b)
      ara_clr && !fault |=> !alert_r ##1 !alert_out_n_oe;
  endproperty
  a_ara_release: assert property (p_ara_release) // R15
    else $error("alert not released after response read");

  property p_alert_hold;
    @(posedge mclk) disable iff (!rst_b)
      alert_r && !ara_clr |=> alert_r;
  endproperty
  a_alert_hold: assert property (p_alert_hold) // R16
    else $error("alert released without response read");

  property p_mask_no_ara;
    @(posedge mclk) disable iff (!rst_b)
      ev.rx_valid && st_r == X_ADDR && mask &&
      ev.rx_byte[7:1] == `ARA_ADDR |=> !ara_sel_r;
  endproperty
  a_mask_no_ara: assert property (p_mask_no_ara) // R7
    else $error("masked device took the alert response");

  property p_standby_abort;
    @(posedge mclk) disable iff (!rst_b)
      stby_wr && conv_busy |=> conv_abort && !conv_busy;
  endproperty
  a_standby_abort: assert property (p_standby_abort) // R1
    else $error("standby write did not abort conversion");

  property p_one_shot;
    @(posedge mclk) disable iff (!rst_b)
      conv_start && $past(standby) |-> $past(one_shot_req);
  endproperty
  a_one_shot: assert property (p_one_shot) // R2
    else $error("standby conversion without one-shot");

  property p_auto_start;
    @(posedge mclk) disable iff (!rst_b)
      auto_due && !conv_busy && !stby_wr |=> conv_start && conv_busy ##1
      (conv_busy || $past(stby_wr));
  endproperty
  a_auto_start: assert property (p_auto_start) // R3
    else $error("timed conversion did not start");

  property p_reset_state;
    @(posedge mclk) disable iff (!rst_b)
      boot_cnt_r == 2'h1 |-> !standby && !mask &&
      rate_r == `RATE_RESET && period_ticks == `PERIOD_AT_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) // R4
    else $error("wrong state after reset");

  property p_cfg_write;
    @(posedge mclk) disable iff (!rst_b)
      cfg_wr |=> config_r == $past(ev.rx_byte);
  endproperty
  a_cfg_write: assert property (p_cfg_write) // R5
    else $error("config write not stored");

  property p_addr_latch;
    @(posedge mclk) disable iff (!rst_b)
      conv_start |-> own_addr_r == addr_of($past(sel_s_r));
  endproperty
  a_addr_latch: assert property (p_addr_latch) // R20
    else $error("select pins not latched at conversion");
endmodule

/* smb_host_model.sv */
`timescale 1ns/100ps
// smbus master; data idles high through a pull-up and the master only pulls it low, clock driven both ways
module smb_host_model (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end

  // data moves two mclk after a clock fall, giving the receiver hold time
  task automatic wait_q(input int n);
    repeat (2 * n) @(negedge mclk);
  endtask

  // also a repeated start: clock is low and data released on entry
  task automatic start_cond();
    sda_drv = 1'b0;
    wait_q(2);
    scl = 1'b1;
    wait_q(2);
    sda_drv = 1'b1;
    wait_q(2);
    scl = 1'b0;
    wait_q(1);
  endtask

  task automatic stop_cond();
    sda_drv = 1'b1;
    wait_q(2);
    scl = 1'b1;
    wait_q(2);
    sda_drv = 1'b0;
    wait_q(2);
  endtask

  // one clock pulse, data sampled mid high phase
  task automatic pulse(output logic seen);
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    seen = sda_line;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask

  // msb first, ninth clock carries the receiver's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      sda_drv = ~b[i];
      pulse(seen);
    end
    sda_drv = 1'b0;
    pulse(seen);
    ack = ~seen;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic seen;
    sda_drv = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(seen);
      b[i] = seen;
    end
    sda_drv = ~last;
    pulse(seen);
    sda_drv = 1'b0;
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import thermal_sensor_pkg::*;
  localparam int TICKS = 16;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, host_drv, sda_oe, alert_oe;
  logic conv_start, conv_abort, conv_busy;
  logic conv_done = 1'b0;
  logic limit_fault = 1'b0;
  logic diode_open = 1'b0;
  logic hold_done = 1'b0;
  logic [7:0] ext_rd = 8'h5A;
  logic [7:0] ext_data, cmd_ptr;
  logic [7:0] ext_seen = 8'h00;
  logic ext_stb, dat_out, alert_out;
  int n_ext = 0;
  sel_pin_s [1:0] sel = '0;
  logic [6:0] own = 7'h18;
  logic [31:0] lfsr = 32'hF63637C9;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_start = 0;
  int n_abort = 0;
  int gap = 0;
  int since = 0;
  int done_cnt = 0;
  // open-drain lines with pull-ups
  wire sda = ~(host_drv | (sda_oe & ~dat_out));
  wire alert_n = ~(alert_oe & ~alert_out);

  always #5 mclk = ~mclk;

  thermal_sensor_ctrl #(.TICK_CYCLES(TICKS)) thermal_sensor_ctrl_i (
    .mclk(mclk), .rst_b(rst_b), .smb_clk(scl), .smb_dat_in(sda),
    .smb_dat_out(dat_out), .smb_dat_oe(sda_oe),
    .alert_out_n_out(alert_out),
    .alert_out_n_oe(alert_oe), .sensor_addr_select(sel),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_busy(conv_busy), .conv_done(conv_done),
    .limit_fault(limit_fault), .diode_open(diode_open),
    .cmd_ptr(cmd_ptr),
    .ext_rd_byte(ext_rd), .ext_wr_stb(ext_stb), .ext_wr_data(ext_data));

  smb_host_model smb_host_model_i (.mclk(mclk), .sda_line(sda),
    .scl(scl), .sda_drv(host_drv));

  // conversion monitor and cycle ceiling
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    since <= since + 1;
    if (conv_start) begin
      n_start <= n_start + 1;
      gap <= since + 1;
      since <= 0;
    end
    if (conv_abort)
      n_abort <= n_abort + 1;
    if (ext_stb) begin
      n_ext <= n_ext + 1;
      ext_seen <= ext_data;
    end
    if (cycles == 90000) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t run did not finish in time", $time);
      summarize();
    end
  end

  // converter stand-in with a random finish delay; can be held busy
  always @(negedge mclk) begin
    conv_done <= (done_cnt == 1);
    if (conv_start && !hold_done)
      done_cnt <= 2 + int'(lfsr[2:0]);
    else if (done_cnt > 0)
      done_cnt <= done_cnt - 1;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  // levels 0 low, 1 floating, 2 high; no address has a zero nibble
  function automatic logic [6:0] addr_of(input int l0, input int l1);
    logic [3:0] nib [3] = '{4'h3, 4'h5, 4'h9};
    logic [2:0] base [3] = '{3'h0, 3'h1, 3'h4};
    return {nib[l0], base[l0] + 3'(l1)};
  endfunction

  function automatic sel_pin_s pin_of(input int l);
    return sel_pin_s'((l == 0) ? 2'b00 : (l == 1) ? 2'b10 : 2'b11);
  endfunction

  // reserved codes run at the fastest rate
  function automatic int period_of(input int r);
    return (r > 7) ? TICKS : TICKS << (7 - r);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d,
                    input logic two);
    logic a;
    smb_host_model_i.start_cond();
    smb_host_model_i.put_byte({own, 1'b0}, a);
    check(8'(a), 8'h01, "address ack");
    smb_host_model_i.put_byte(cmd, a);
    if (two)
      smb_host_model_i.put_byte(d, a);
    smb_host_model_i.stop_cond();
  endtask

  task automatic rd(input logic [6:0] adr, input logic [7:0] cmd,
                    output logic ack, output logic [7:0] d);
    smb_host_model_i.start_cond();
    smb_host_model_i.put_byte({adr, 1'b0}, ack);
    d = 8'hFF;
    if (ack) begin
      smb_host_model_i.put_byte(cmd, ack);
      smb_host_model_i.start_cond();
      smb_host_model_i.put_byte({adr, 1'b1}, ack);
      smb_host_model_i.get_byte(1'b1, d);
    end
    smb_host_model_i.stop_cond();
  endtask

  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    rd(own, cmd, a, d);
    check(d, exp, "register read");
  endtask

  // the host clears a latched alert only through this read
  task automatic ara(output logic ack, output logic [7:0] d);
    smb_host_model_i.start_cond();
    smb_host_model_i.put_byte({7'h0C, 1'b1}, ack);
    d = 8'hFF;
    if (ack)
      smb_host_model_i.get_byte(1'b1, d);
    smb_host_model_i.stop_cond();
  endtask

  task automatic wait_start();
    int s;
    s = n_start;
    for (int i = 0; i < 5000 && n_start == s; i++)
      @(negedge mclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    logic a;
    logic [7:0] d, v;
    int s0, a0;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h02);
    v = rnd() & 8'h3F;
    wr(8'h09, v, 1'b1);
    rd_chk(8'h03, v);
    rd_chk(8'h04, 8'h02);
    // a write through a read code goes to the outside bank
    a0 = n_ext;
    wr(8'h03, ~v, 1'b1);
    check(8'(n_ext - a0), 8'h01, "write through read code");
    check(ext_seen, ~v, "outside write data");
    rd_chk(8'h03, v);
    ext_rd = rnd();
    rd_chk(8'h01, ext_rd);
    check(cmd_ptr, 8'h01, "command pointer");
    $display("register test done");
    // every rate code plus one reserved code, timing within 30 percent
    for (int r = 0; r <= 8; r++) begin
      v = (r == 8) ? (rnd() | 8'h08) : 8'(r);
      wr(8'h0A, v, 1'b1);
      rd_chk(8'h04, v);
      wait_start();
      wait_start();
      wait_start();
      s0 = period_of(r);
      check(8'(gap * 10 >= s0 * 7 && gap * 10 <= s0 * 13), 8'h01,
            "conversion period");
    end
    wr(8'h0A, 8'h07, 1'b1);
    $display("rate test done");
    // standby while a conversion is in flight
    hold_done = 1'b1;
    wait_start();
    repeat (2) @(negedge mclk);
    check(8'(conv_busy), 8'h01, "busy during conversion");
    a0 = n_abort;
    wr(8'h09, 8'h40, 1'b1);
    check(8'(n_abort - a0), 8'h01, "abort on standby");
    check(8'(conv_busy), 8'h00, "busy after standby");
    hold_done = 1'b0;
    s0 = n_start;
    repeat (300) @(negedge mclk);
    check(8'(n_start - s0), 8'h00, "no timed starts");
    wr(8'h0F, 8'h00, 1'b0);
    repeat (200) @(negedge mclk);
    check(8'(n_start - s0), 8'h01, "one-shot start");
    wr(8'h09, 8'h00, 1'b1);
    // a timed start may already fall inside the write frame
    s0 = n_start;
    wait_start();
    check(8'(n_start - s0), 8'h01, "auto resumes");
    $display("mode test done");
    // alert latch, mask and response read
    limit_fault = 1'b1;
    @(negedge mclk);
    limit_fault = 1'b0;
    repeat (4) @(negedge mclk);
    check(8'(alert_n), 8'h00, "alert driven");
    wr(8'h09, 8'h80, 1'b1);
    check(8'(alert_n), 8'h01, "alert masked");
    ara(a, d);
    check(8'(a), 8'h00, "response refused");
    wr(8'h09, 8'h00, 1'b1);
    check(8'(alert_n), 8'h00, "alert kept");
    ara(a, d);
    check(d, {own, 1'b1}, "response address");
    repeat (4) @(negedge mclk);
    check(8'(alert_n), 8'h01, "alert released");
    diode_open = 1'b1;
    repeat (4) @(negedge mclk);
    ara(a, d);
    repeat (4) @(negedge mclk);
    check(8'(alert_n), 8'h00, "fault persists");
    diode_open = 1'b0;
    ara(a, d);
    repeat (4) @(negedge mclk);
    check(8'(alert_n), 8'h01, "alert cleared");
    $display("alert test done");
    // all nine pin combinations, picked up at conversion starts
    for (int k = 0; k < 9; k++) begin
      sel[0] = pin_of(k % 3);
      sel[1] = pin_of(k / 3);
      wait_start();
      wait_start();
      own = addr_of(k % 3, k / 3);
      rd(own, 8'h04, a, d);
      check(d, 8'h07, "read at new address");
      rd(own ^ 7'h01, 8'h04, a, d);
      check(8'(a), 8'h00, "foreign address");
    end
    // in standby pins are not sampled until a one-shot starts
    wr(8'h09, 8'h40, 1'b1);
    sel = '0;
    repeat (100) @(negedge mclk);
    rd_chk(8'h03, 8'h40);
    wr(8'h0F, 8'h00, 1'b0);
    repeat (100) @(negedge mclk);
    own = 7'h18;
    rd_chk(8'h03, 8'h40);
    $display("address test done");
    summarize();
  end
endmodule
